// >>> verilog/tcsac_defines.svh
`ifndef TCSAC_DEFINES_SVH
`define TCSAC_DEFINES_SVH

// ==========================================================
// register byte offsets
`define TCSAC_OFS_VEC 8'h00
`define TCSAC_OFS_CTL 8'h04
`define TCSAC_OFS_STS 8'h08
`define TCSAC_OFS_MSK 8'h0c
`define TCSAC_OFS_BASE 8'h10
`define TCSAC_OFS_STATE 8'h14

// ==========================================================
// field positions
`define TCSAC_EN_BIT 7
`define TCSAC_INTSEL_BIT 0
`define TCSAC_STS_SWEND_BIT 0
`define TCSAC_STS_PEREND_BIT 1
`define TCSAC_CHAIN_BIT 31
`define TCSAC_STS_W 2

// ==========================================================
// reset values
`define TCSAC_RST_VEC 8'h00
`define TCSAC_RST_CTL 1'b0
`define TCSAC_RST_STS 2'h0
`define TCSAC_RST_MSK 2'h0
`define TCSAC_RST_BASE 32'h0000_0000

// ==========================================================
// register information layout, byte steps
`define TCSAC_INFO_SRC 32'h0000_0004
`define TCSAC_INFO_DST 32'h0000_0008
`define TCSAC_INFO_SIZE 32'h0000_000c

`endif

// >>> verilog/tcsac_pkg.sv
package tcsac_pkg;

  // ==========================================================
  // engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_VEC = 3'b001,
    ST_MODE = 3'b010,
    ST_SRC = 3'b011,
    ST_DST = 3'b100,
    ST_RD = 3'b101,
    ST_WR = 3'b110,
    ST_DONE = 3'b111
  } tcsac_state_t;

  // ==========================================================
  // register index
  typedef enum logic [2:0] {
    RG_VEC = 3'b000,
    RG_CTL = 3'b001,
    RG_STS = 3'b010,
    RG_MSK = 3'b011,
    RG_BASE = 3'b100,
    RG_STATE = 3'b101,
    RG_NONE = 3'b111
  } tcsac_reg_t;

endpackage

// >>> verilog/tcsac_top.sv
// How it works
// [R1] The activation enable bit takes only a written 1; a written 0 is ignored.
// [R2] The vector number field changes on a write only while the enable bit is 0.
// [R3] Bit 7 of the vector register enables software activation when set.
// [R4] Writing 0 to the interrupt select bit after the end interrupt was raised clears the enable bit.
// [R5] Finishing the last transfer never clears the requesting peripheral's source flag.
// [R6] An activation reads the start address from its vector entry, then the first information set there.
// [R7] After each transfer a set chain bit fetches the next adjacent set and transfers again.
// [R8] The chain ends, and the activation with it, at a set whose chain bit is 0.
// [R9] After reset the enable bit and the vector number field are 0.
// [R10] A software activation picks its vector entry by the vector number field.
`include "tcsac_defines.svh"

module tcsac_top
  import tcsac_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // peripheral activation
  input wire logic periph_req,
  input wire logic [6:0] periph_vec,
  output logic periph_ack,
  // memory master
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  // interrupt
  output logic irq
);

  // ==========================================================
  // address decode
  function automatic tcsac_reg_t reg_dec(input logic [7:0] a);
    case (a)
      `TCSAC_OFS_VEC: reg_dec = RG_VEC;
      `TCSAC_OFS_CTL: reg_dec = RG_CTL;
      `TCSAC_OFS_STS: reg_dec = RG_STS;
      `TCSAC_OFS_MSK: reg_dec = RG_MSK;
      `TCSAC_OFS_BASE: reg_dec = RG_BASE;
      `TCSAC_OFS_STATE: reg_dec = RG_STATE;
      default: reg_dec = RG_NONE;
    endcase
  endfunction

  tcsac_reg_t idx;
  logic rd_setup;
  logic wr_acc;
  logic [7:0] vec_r, vec_nxt;
  logic intsel_r, intsel_nxt;
  logic end_req_r, end_req_nxt;
  logic [`TCSAC_STS_W-1:0] sts_r, sts_nxt, msk_r, msk_nxt, sts_set;
  logic [31:0] base_r, base_nxt, prdata_r, prdata_nxt;
  logic clr_en;
  tcsac_state_t state_r, state_nxt;
  logic [31:0] addr_r, addr_nxt, info_r, info_nxt, src_r, src_nxt, wdata_r, wdata_nxt;
  logic we_r, we_nxt, chain_r, chain_nxt, sw_act_r, sw_act_nxt;

  assign idx = reg_dec(paddr);
  assign rd_setup = psel && !penable && !pwrite;
  assign wr_acc = psel && penable && pwrite && idx != RG_NONE;
  assign pready = 1'b1;
  assign pslverr = psel && penable && idx == RG_NONE;
  assign prdata = prdata_r;
  assign irq = |(sts_r & msk_r);
  assign clr_en = wr_acc && idx == RG_CTL && !pwdata[`TCSAC_INTSEL_BIT] && end_req_r; // R4
  assign sts_set[`TCSAC_STS_SWEND_BIT] = state_r == ST_DONE && sw_act_r;
  assign sts_set[`TCSAC_STS_PEREND_BIT] = state_r == ST_DONE && !sw_act_r;

  // ==========================================================
  // register file
  always_comb
  begin
    vec_nxt = vec_r;
    intsel_nxt = intsel_r;
    end_req_nxt = end_req_r;
    sts_nxt = sts_r;
    msk_nxt = msk_r;
    base_nxt = base_r;
    prdata_nxt = prdata_r;
    if (rd_setup)
    begin
      case (idx)
        RG_VEC: prdata_nxt = {24'h00_0000, vec_r};
        RG_CTL: prdata_nxt = {31'h0000_0000, intsel_r};
        RG_STS: prdata_nxt = {30'h0000_0000, sts_r};
        RG_MSK: prdata_nxt = {30'h0000_0000, msk_r};
        RG_BASE: prdata_nxt = base_r;
        RG_STATE: prdata_nxt = {27'h000_0000, end_req_r, sw_act_r, state_r};
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
    if (clr_en)
    begin
      vec_nxt[`TCSAC_EN_BIT] = 1'b0; // R4
      end_req_nxt = 1'b0;
    end
    if (wr_acc)
    begin
      case (idx)
        RG_VEC:
        begin
          if (!vec_r[`TCSAC_EN_BIT])
            vec_nxt[6:0] = pwdata[6:0]; // R2
          if (pwdata[`TCSAC_EN_BIT])
            vec_nxt[`TCSAC_EN_BIT] = 1'b1; // R1
        end
        RG_CTL: intsel_nxt = pwdata[`TCSAC_INTSEL_BIT];
        RG_STS: sts_nxt = sts_r & ~pwdata[`TCSAC_STS_W-1:0];
        RG_MSK: msk_nxt = pwdata[`TCSAC_STS_W-1:0];
        RG_BASE: base_nxt = pwdata;
        default: ;
      endcase
    end
    // set wins over a same-cycle clear
    sts_nxt = sts_nxt | sts_set;
    if (sts_set[`TCSAC_STS_SWEND_BIT])
      end_req_nxt = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vec_r <= `TCSAC_RST_VEC; // R9
      intsel_r <= `TCSAC_RST_CTL;
      end_req_r <= 1'b0;
      sts_r <= `TCSAC_RST_STS;
      msk_r <= `TCSAC_RST_MSK;
      base_r <= `TCSAC_RST_BASE;
      prdata_r <= 32'h0000_0000;
    end
    else
    begin
      vec_r <= vec_nxt;
      intsel_r <= intsel_nxt;
      end_req_r <= end_req_nxt;
      sts_r <= sts_nxt;
      msk_r <= msk_nxt;
      base_r <= base_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // ==========================================================
  // transfer engine
  assign mem_req = state_r != ST_IDLE && state_r != ST_DONE;
  assign mem_we = we_r;
  assign mem_addr = addr_r;
  assign mem_wdata = wdata_r;
  // accept only; the source flag stays with the peripheral
  assign periph_ack = state_r == ST_IDLE && periph_req; // R5

  always_comb
  begin
    state_nxt = state_r;
    addr_nxt = addr_r;
    info_nxt = info_r;
    src_nxt = src_r;
    wdata_nxt = wdata_r;
    we_nxt = we_r;
    chain_nxt = chain_r;
    sw_act_nxt = sw_act_r;
    unique case (state_r)
      ST_IDLE:
      begin
        if (periph_req)
        begin
          state_nxt = ST_VEC;
          sw_act_nxt = 1'b0;
          addr_nxt = base_r + {23'h00_0000, periph_vec, 2'b00}; // R6
        end
        else if (vec_r[`TCSAC_EN_BIT] && !end_req_r) // R3
        begin
          state_nxt = ST_VEC;
          sw_act_nxt = 1'b1;
          addr_nxt = base_r + {23'h00_0000, vec_r[6:0], 2'b00}; // R10
        end
      end
      ST_VEC:
        if (mem_ack)
        begin
          info_nxt = mem_rdata; // R6
          addr_nxt = mem_rdata;
          state_nxt = ST_MODE;
        end
      ST_MODE:
        if (mem_ack)
        begin
          chain_nxt = mem_rdata[`TCSAC_CHAIN_BIT];
          addr_nxt = info_r + `TCSAC_INFO_SRC;
          state_nxt = ST_SRC;
        end
      ST_SRC:
        if (mem_ack)
        begin
          src_nxt = mem_rdata;
          addr_nxt = info_r + `TCSAC_INFO_DST;
          state_nxt = ST_DST;
        end
      ST_DST:
        if (mem_ack)
        begin
          wdata_nxt = mem_rdata;
          addr_nxt = src_r;
          state_nxt = ST_RD;
        end
      ST_RD:
        if (mem_ack)
        begin
          addr_nxt = wdata_r;
          wdata_nxt = mem_rdata;
          we_nxt = 1'b1;
          state_nxt = ST_WR;
        end
      ST_WR:
        if (mem_ack)
        begin
          we_nxt = 1'b0;
          if (chain_r)
          begin
            info_nxt = info_r + `TCSAC_INFO_SIZE; // R7
            addr_nxt = info_r + `TCSAC_INFO_SIZE;
            state_nxt = ST_MODE;
          end
          else
            state_nxt = ST_DONE; // R8
        end
      ST_DONE: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= ST_IDLE;
      addr_r <= 32'h0000_0000;
      info_r <= 32'h0000_0000;
      src_r <= 32'h0000_0000;
      wdata_r <= 32'h0000_0000;
      we_r <= 1'b0;
      chain_r <= 1'b0;
      sw_act_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      info_r <= info_nxt;
      src_r <= src_nxt;
      wdata_r <= wdata_nxt;
      we_r <= we_nxt;
      chain_r <= chain_nxt;
      sw_act_r <= sw_act_nxt;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  en_write_zero_a: assert property ( // R1
    wr_acc && idx == RG_VEC && !pwdata[7] && !clr_en && vec_r[7] |=> vec_r[7])
    else $error("enable bit cleared by a written zero");

  vec_locked_a: assert property ( // R2
    wr_acc && idx == RG_VEC && vec_r[7] |=> $stable(vec_r[6:0]))
    else $error("vector field changed while enabled");

  vec_update_a: assert property ( // R2
    wr_acc && idx == RG_VEC && !vec_r[7] |=> vec_r[6:0] == $past(pwdata[6:0]))
    else $error("vector field missed a write while disabled");

  sw_start_a: assert property ( // R3
    state_r == ST_IDLE && vec_r[7] && !end_req_r && !periph_req
    |=> state_r == ST_VEC && sw_act_r && mem_addr == $past(base_r) + {23'h00_0000, $past(vec_r[6:0]), 2'b00})
    else $error("software activation not started from its vector entry");

  intsel_clear_a: assert property ( // R4
    clr_en && !sts_set[0] |=> !vec_r[7] && !end_req_r)
    else $error("enable bit not cleared by select write");

  no_flag_clear_a: assert property ( // R5
    periph_ack |-> state_r == ST_IDLE ##1 state_r == ST_VEC && !sw_act_r)
    else $error("peripheral accept outside idle start");

  vec_fetch_a: assert property ( // R6
    state_r == ST_VEC && mem_ack |=> state_r == ST_MODE && mem_addr == $past(mem_rdata) && !mem_we)
    else $error("start address not used for first fetch");

  chain_next_a: assert property ( // R7
    state_r == ST_WR && mem_ack && chain_r |=> state_r == ST_MODE && mem_addr == $past(info_r) + 32'h0000_000c)
    else $error("chained set not fetched from next area");

  chain_end_a: assert property ( // R8
    state_r == ST_WR && mem_ack && !chain_r |=> state_r == ST_DONE ##1 state_r == ST_IDLE && sts_r != 2'h0)
    else $error("activation did not end on cleared chain bit");

  sw_end_cov: cover property (state_r == ST_DONE && sw_act_r ##1 irq);
  chain_cov: cover property (state_r == ST_WR && mem_ack && chain_r);
  periph_cov: cover property (periph_ack ##[1:40] state_r == ST_DONE);
  intsel_cov: cover property (clr_en);

endmodule // tcsac_top

// >>> testbench/tcsac_mem.sv
module tcsac_mem (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pacing
  input wire logic slow,
  // memory slave
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic [31:0] mem_rdata,
  output logic mem_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // storage and pacing
  logic [31:0] words [0:255];
  logic [1:0] wait_r;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wait_r <= 2'h0;
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0;
    end
    else
    begin
      mem_ack <= 1'b0;
      // idle data toggles, so a stale word returns only every other cycle
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack)
      begin
        wait_r <= wait_r + 2'h1;
        if (!slow || wait_r == 2'h2)
        begin
          wait_r <= 2'h0;
          mem_ack <= 1'b1;
          mem_rdata <= words[mem_addr[9:2]];
          if (mem_we)
            words[mem_addr[9:2]] <= mem_wdata;
        end
      end
    end
  end
endmodule // tcsac_mem

// >>> testbench/test_tcsac_top.sv
`include "tcsac_defines.svh"

module test_tcsac_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic periph_req = 1'b0;
  logic [6:0] periph_vec = 7'h00;
  logic slow = 1'b0;
  logic [31:0] prdata, mem_addr, mem_wdata, mem_rdata, q;
  logic pready, pslverr, periph_ack, mem_req, mem_we, mem_ack, irq, e;
  int n_mismatch = 0;
  int num_checks = 0;
  int cnt;

  always #10 pclk = ~pclk;

  tcsac_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periph_req(periph_req), .periph_vec(periph_vec), .periph_ack(periph_ack), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .irq(irq));
  tcsac_mem mem (.pclk(pclk), .presetn(presetn), .slow(slow), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  // ==========
  // shared tasks
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic late();
    chk("wait", 32'h1, 32'h0);
    stop_test();
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    repeat (20)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (pready !== 1'b1)
      late();
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    apb(1'b0, a, 32'h0);
    chk(name, exp, q);
  endtask

  task automatic wait_irq();
    repeat (300)
    begin
      @(posedge pclk);
      if (irq === 1'b1)
        return;
    end
    late();
  endtask

  task automatic wait_idle();
    repeat (50)
    begin
      apb(1'b0, `TCSAC_OFS_STATE, 32'h0);
      if (q[2:0] === 3'h0)
        return;
    end
    late();
  endtask

  // ==========
  // scenarios
  task automatic t_sw();
    apb(1'b1, `TCSAC_OFS_BASE, 32'h100);
    apb(1'b1, `TCSAC_OFS_MSK, 32'h1);
    apb(1'b1, `TCSAC_OFS_VEC, 32'h05);
    rd(`TCSAC_OFS_VEC, 32'h05, "vec");
    apb(1'b1, `TCSAC_OFS_VEC, 32'h85);
    apb(1'b1, `TCSAC_OFS_VEC, 32'h03);
    wait_irq();
    rd(`TCSAC_OFS_VEC, 32'h85, "vec");
    chk("dst0", 32'hcafe_0001, mem.words[224]);
    chk("dst1", 32'hbeef_0002, mem.words[225]);
    chk("dst2", 32'h0, mem.words[226]);
    apb(1'b1, `TCSAC_OFS_CTL, 32'h1);
    rd(`TCSAC_OFS_CTL, 32'h1, "ctl");
    rd(`TCSAC_OFS_VEC, 32'h85, "vec");
    apb(1'b1, `TCSAC_OFS_CTL, 32'h0);
    rd(`TCSAC_OFS_VEC, 32'h05, "vec");
    rd(`TCSAC_OFS_CTL, 32'h0, "ctl");
    apb(1'b1, `TCSAC_OFS_STS, 32'h1);
    rd(`TCSAC_OFS_STS, 32'h0, "sts");
    chk("irq", 32'h0, {31'h0, irq});
  endtask

  task automatic t_periph();
    slow <= 1'b1;
    apb(1'b1, `TCSAC_OFS_MSK, 32'h2);
    periph_vec <= 7'h06;
    periph_req <= 1'b1;
    cnt = 0;
    repeat (90)
    begin
      @(posedge pclk);
      if (periph_ack === 1'b1)
        cnt++;
    end
    periph_req <= 1'b0;
    chk("retrigger", 32'h1, {31'h0, cnt >= 2});
    wait_idle();
    chk("dst3", 32'h5a5a_0004, mem.words[227]);
    rd(`TCSAC_OFS_STS, 32'h2, "sts");
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 32'h1, {31'h0, e});
    chk("rdata", 32'h0, q);
  endtask

  initial
  begin
    for (int i = 0; i < 256; i++)
      mem.words[i] = 32'h0;
    mem.words[69] = 32'h200;
    mem.words[70] = 32'h240;
    // three chained sets, the second ends the chain
    mem.words[128] = 32'h8000_0000;
    mem.words[129] = 32'h300;
    mem.words[130] = 32'h380;
    mem.words[132] = 32'h304;
    mem.words[133] = 32'h384;
    mem.words[135] = 32'h308;
    mem.words[136] = 32'h388;
    mem.words[145] = 32'h30c;
    mem.words[146] = 32'h38c;
    mem.words[192] = 32'hcafe_0001;
    mem.words[193] = 32'hbeef_0002;
    mem.words[194] = 32'h1234_5678;
    mem.words[195] = 32'h5a5a_0004;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(`TCSAC_OFS_VEC, 32'h00, "vec");
    t_sw();
    t_periph();
    stop_test();
  end
endmodule // test_tcsac_top
